// [pkg/epas_map.svh]
`ifndef EPAS_MAP_SVH
`define EPAS_MAP_SVH
// ****************************************
// Register map of the plain register port
// ****************************************
`define EPAS_REG_CFG      4'h0
`define EPAS_REG_STAT     4'h1
`define EPAS_CFG_RST      14'h000c
`define EPAS_PACK_FULL    2'h1
// ****************************************
// Address space decode
// ****************************************
`define EPAS_MP_BASE      32'h0010_0000
`define EPAS_EXT_BASE     32'h0020_0000
`define EPAS_PEER_MASK    32'h0000_ffff
`define EPAS_IOP_SPAN     32'h0000_0200
`define EPAS_BANK_SZ      32'h0100_0000
`define EPAS_SDBANK_SZ    32'h0400_0000
`define EPAS_BANKS        4
`define EPAS_UPPER_LANES  32
`define EPAS_LANE_W       8
`define EPAS_ACK_LAT      4'h1
`endif

// [pkg/epas_pkg.sv]
package epas_pkg;
  // ****************************************
  // Access sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    EPAS_IDLE  = 2'b00,
    EPAS_SETUP = 2'b01,
    EPAS_WAIT  = 2'b10,
    EPAS_ACK   = 2'b11
  } epas_state_t;

  // Configuration register layout, lsb last
  typedef struct packed {
    logic [3:0] wait_cnt;
    logic [3:0] sdram_mask;
    logic       sdram_half;
    logic       sync_mode;
    logic       link1_used;
    logic       link0_used;
    logic [1:0] instr_pack_mode;
  } epas_cfg_t;

  // Status register layout, lsb last
  typedef struct packed {
    logic       suspended;
    logic       master;
    logic [3:0] mon_bank_n;
    logic       wide_ok;
    logic       refused;
    logic       busy;
  } epas_stat_t;

  // Pin levels driven by the port
  typedef struct packed {
    logic [23:0] addr;
    logic        addr_oe;
    logic [47:0] data;
    logic [47:0] data_oe;
    logic [3:0]  bank_select_n;
    logic        bank_oe;
    logic        rd_n;
    logic        wr_n;
    logic        strobe_oe;
  } epas_pins_o_t;

  // Pin levels seen by the port
  typedef struct packed {
    logic [23:0] addr;
    logic [47:0] data;
    logic [3:0]  bank_select_n;
    logic        ack;
    logic        suspend_bus_tristate_n;
    logic        rd_n;
    logic        wr_n;
    logic        bus_master;
  } epas_pins_i_t;

  // Core access request
  typedef struct packed {
    logic        instr;
    logic        write;
    logic [31:0] addr;
    logic [47:0] wdata;
  } epas_req_t;

  // Register access by a host or peer while slave
  typedef struct packed {
    logic        write;
    logic [23:0] addr;
    logic [47:0] wdata;
  } epas_slv_t;

  // Whole state of the port
  typedef struct packed {
    epas_state_t  st;
    epas_pins_o_t pins;
    epas_cfg_t    cfg;
    logic         refused;
    logic [3:0]   cnt;
    logic         tick;
    logic         ext;
    epas_req_t    req;
    logic         req_ready;
    logic         resp_valid;
    logic         resp_err;
    logic [47:0]  resp_rdata;
    logic         slv_valid;
    epas_slv_t    slv;
    logic         rd_n_d;
    logic         wr_n_d;
    logic [31:0]  reg_rdata;
  } epas_st_t;
endpackage

// [src/epas_sync.sv]
`timescale 1ns/100ps
// Two-stage synchroniser; only the second stage leaves the module
module epas_sync
  import epas_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  // Per-bit double flop, reset to the idle pin level
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (srst) begin
          s1_r[i] <= rst_val[i];
          s2_r[i] <= rst_val[i];
        end else begin
          s1_r[i] <= d[i];
          s2_r[i] <= s1_r[i];
        end
      end
    end
  endgenerate

  assign q = s2_r;
endmodule

// [src/epas_bank_dec.sv]
`timescale 1ns/100ps
`include "epas_map.svh"
// Bank decode: banks are laid out back to back from the external base
module epas_bank_dec
  import epas_pkg::*;
(
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  sdram_mask,
  output logic      [3:0]  sel,
  output logic             hit
);
  logic [31:0] start [0:`EPAS_BANKS];

  assign start[0] = `EPAS_EXT_BASE;

  // Each bank size is fixed by its memory type
  genvar i;
  generate
    for (i = 0; i < `EPAS_BANKS; i++) begin : g_bank
      assign start[i+1] = start[i] + (sdram_mask[i] ? `EPAS_SDBANK_SZ
                                                    : `EPAS_BANK_SZ);
      assign sel[i] = (addr >= start[i]) && (addr < start[i+1]);
    end
  endgenerate

  assign hit = |sel;
endmodule

// [src/epas_port.sv]
//
// Notes on behaviour
// RULE1: Drive the 24-bit address on pins during every external access.
// RULE2: As master reach peer IO registers directly; other peer memory refused.
// RULE3: Address pins become inputs while a host or master reaches us.
// RULE4: Data bits 47..16 always carry data and instructions both ways.
// RULE5: Bits 15..8 join the data bus when link port 1 is unused.
// RULE6: Bits 7..0 join the data bus when link port 0 is unused.
// RULE7: Full-width bus fetches 48-bit instructions; SDRAM may run half speed.
// RULE8: Pack mode one selects full instruction width without packing.
// RULE9: Four active-low bank selects, decoded from the address.
// RULE10: Banks are 16 Mwords, or 64 Mwords when typed as SDRAM.
// RULE11: Asynchronous mode: bank selects change together with the address.
// RULE12: Synchronous mode: select drops after first cycle with ack high.
// RULE13: As slave, follow the bank selects driven by the master.
// RULE14: Outputs float while bus suspended or while slave; as slave the code still drives the data lanes with the read answer.
// RULE15: Ack held low stretches the access until it returns high.
// RULE16: Bank selects stay high while no external access runs.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "epas_map.svh"
module epas_port
  import epas_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         srst,
  // Register port
  input  wire logic [3:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  // Core access port
  input  wire logic         req_valid,
  input  wire epas_req_t    req,
  output logic              req_ready,
  output logic              resp_valid,
  output logic              resp_err,
  output logic      [47:0]  resp_rdata,
  // Slave register access port
  output logic              slv_valid,
  output epas_slv_t         slv,
  input  wire logic [47:0]  slv_rdata,
  // External pins
  input  wire epas_pins_i_t pins_i,
  output epas_pins_o_t      pins_o
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  epas_pins_i_t pin_s;
  epas_pins_i_t pin_idle;

  // Idle pin levels: strobes and selects high, ack high, not suspended
  always_comb begin
    pin_idle = '0;
    pin_idle.bank_select_n = '1;
    pin_idle.ack = 1'b1;
    pin_idle.suspend_bus_tristate_n = 1'b1;
    pin_idle.rd_n = 1'b1;
    pin_idle.wr_n = 1'b1;
  end

  epas_sync #(
    .W ($bits(epas_pins_i_t))
  ) u_sync (
    .clk     (clk),
    .srst    (srst),
    .d       (pins_i),
    .rst_val (pin_idle),
    .q       (pin_s)
  );

  // ****************************************
  // Bank decode
  // ****************************************
  epas_st_t    cur_r;
  epas_st_t    cur_nxt;
  logic [3:0]  bank_sel;
  logic        bank_hit;

  epas_bank_dec u_dec (
    .addr       (req.addr),
    .sdram_mask (cur_r.cfg.sdram_mask),
    .sel        (bank_sel),
    .hit        (bank_hit)
  );

  // ****************************************
  // Derived terms
  // ****************************************
  logic        suspended;
  logic        drive_ok;
  logic        mp_hit;
  logic        iop_hit;
  logic        wide_ok;
  logic        bad_req;
  logic        go;
  logic [47:0] lane_mask;
  epas_stat_t  stat;

  // Suspend floats every output; slave role floats all but the slave read data
  assign suspended = !pin_s.suspend_bus_tristate_n;
  assign drive_ok  = pin_s.bus_master && !suspended; // RULE14

  // Low lanes are borrowed only from an unused link port
  assign lane_mask = {{`EPAS_UPPER_LANES{1'b1}},              // RULE4
                      {`EPAS_LANE_W{!cur_r.cfg.link1_used}},  // RULE5
                      {`EPAS_LANE_W{!cur_r.cfg.link0_used}}}; // RULE6

  // A 48-bit fetch needs both low lanes and unpacked mode
  assign wide_ok = !cur_r.cfg.link1_used && !cur_r.cfg.link0_used &&
                   (cur_r.cfg.instr_pack_mode == `EPAS_PACK_FULL); // RULE8

  // Peer space: only the IO register window of each peer is reachable
  assign mp_hit  = (req.addr >= `EPAS_MP_BASE) &&
                   (req.addr < `EPAS_EXT_BASE);
  assign iop_hit = mp_hit &&
                   ((req.addr & `EPAS_PEER_MASK) < `EPAS_IOP_SPAN); // RULE2

  // Other peer memory must go through its DMA registers instead
  assign bad_req = (mp_hit && !iop_hit) ||                     // RULE2
                   (!mp_hit && !bank_hit) ||
                   (req.instr && !wide_ok) ||                  // RULE7
                   !pin_s.bus_master;

  assign go = req_valid && cur_r.req_ready;

  // Status word, refused flag is sticky
  always_comb begin
    stat            = '0;
    stat.busy       = (cur_r.st != EPAS_IDLE);
    stat.refused    = cur_r.refused;
    stat.wide_ok    = wide_ok;
    stat.mon_bank_n = pin_s.bank_select_n; // RULE13
    stat.master     = pin_s.bus_master;
    stat.suspended  = suspended;
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.resp_valid = 1'b0;
    cur_nxt.resp_err   = 1'b0;
    cur_nxt.slv_valid  = 1'b0;
    cur_nxt.rd_n_d     = pin_s.rd_n;
    cur_nxt.wr_n_d     = pin_s.wr_n;

    // Divider gives the half-rate enable for SDRAM accesses
    cur_nxt.tick = !cur_r.tick;

    // Output enables follow the role and suspend level every cycle
    cur_nxt.pins.addr_oe   = drive_ok;                  // RULE3
    cur_nxt.pins.bank_oe   = drive_ok;                  // RULE14
    cur_nxt.pins.strobe_oe = drive_ok;
    cur_nxt.pins.data_oe   = '0;

    // Register writes
    if (reg_wr && reg_addr == `EPAS_REG_CFG) begin
      cur_nxt.cfg = epas_cfg_t'(reg_wdata[$bits(epas_cfg_t)-1:0]);
    end
    if (reg_wr && reg_addr == `EPAS_REG_STAT && reg_wdata[1]) begin
      cur_nxt.refused = 1'b0;
    end

    // Register reads, answer stands one cycle later
    cur_nxt.reg_rdata = '0;
    if (reg_rd && reg_addr == `EPAS_REG_CFG) begin
      cur_nxt.reg_rdata = 32'(cur_r.cfg);
    end else if (reg_rd && reg_addr == `EPAS_REG_STAT) begin
      cur_nxt.reg_rdata = 32'(stat);
    end

    case (cur_r.st)
      EPAS_IDLE: begin
        cur_nxt.pins.bank_select_n = '1; // RULE16
        cur_nxt.pins.rd_n = 1'b1;
        cur_nxt.pins.wr_n = 1'b1;
        cur_nxt.req_ready = 1'b1;
        if (go && bad_req) begin
          // Refusal sets the sticky flag; it wins over a clear
          cur_nxt.resp_valid = 1'b1;
          cur_nxt.resp_err   = 1'b1;
          cur_nxt.refused    = 1'b1;
        end else if (go) begin
          cur_nxt.req       = req;
          cur_nxt.ext       = bank_hit;
          cur_nxt.req_ready = 1'b0;
          cur_nxt.st        = EPAS_SETUP;
        end
      end
      EPAS_SETUP: begin
        // While suspended the access halts here, outputs floating
        if (!suspended) begin
          cur_nxt.pins.addr = cur_r.req.addr[23:0];  // RULE1
          // Select asserts in the same cycle as the address
          cur_nxt.pins.bank_select_n = cur_r.ext ?
            ~bank_sel_q(cur_r.req.addr, cur_r.cfg.sdram_mask)
            : '1;                                    // RULE9 RULE11
          cur_nxt.pins.rd_n = cur_r.req.write;
          cur_nxt.pins.wr_n = !cur_r.req.write;
          cur_nxt.pins.data = cur_r.req.wdata & lane_mask;
          // Synchronous mode has no programmed wait states
          cur_nxt.cnt = cur_r.cfg.sync_mode ? '0 : cur_r.cfg.wait_cnt;
          cur_nxt.st  = EPAS_WAIT;
        end
      end
      EPAS_WAIT: begin
        // Programmed wait states; SDRAM at half rate counts on the enable
        if (cur_r.cnt == '0) begin
          cur_nxt.st  = EPAS_ACK;
          cur_nxt.cnt = `EPAS_ACK_LAT;
        end else if (step_ok(cur_r)) begin
          cur_nxt.cnt = cur_r.cnt - 4'h1;
        end
      end
      EPAS_ACK: begin
        // Ack and read data arrive two flops late, so the first samples
        // predate the strobe; after that a low ack stretches the access
        if (cur_r.cnt != '0) begin
          cur_nxt.cnt = cur_r.cnt - 4'h1;
        end else if (pin_s.ack && !suspended && step_ok(cur_r)) begin // RULE15
          cur_nxt.pins.bank_select_n = '1;           // RULE12 RULE16
          cur_nxt.pins.rd_n = 1'b1;
          cur_nxt.pins.wr_n = 1'b1;
          if (!cur_r.cfg.sync_mode) begin
            cur_nxt.pins.addr = '0;                  // RULE11
          end
          cur_nxt.resp_valid = 1'b1;
          cur_nxt.resp_rdata = pin_s.data & lane_mask; // RULE7
          cur_nxt.req_ready  = 1'b1;
          cur_nxt.st = EPAS_IDLE;
        end
      end
      default: begin
        cur_nxt.st = EPAS_IDLE;
      end
    endcase

    // Write data lanes drive only while a write is on the bus
    if (cur_r.st != EPAS_IDLE && cur_nxt.st != EPAS_IDLE &&
        cur_r.req.write && drive_ok && !cur_nxt.pins.wr_n) begin
      cur_nxt.pins.data_oe = lane_mask; // RULE4 RULE5 RULE6
    end

    // Slave side: catch a falling strobe from the master or host
    if (!pin_s.bus_master) begin
      cur_nxt.pins.bank_select_n = '1;
      if (cur_r.rd_n_d && !pin_s.rd_n) begin
        cur_nxt.slv_valid   = 1'b1;
        cur_nxt.slv.write   = 1'b0;
        cur_nxt.slv.addr    = pin_s.addr;            // RULE3
      end
      if (cur_r.wr_n_d && !pin_s.wr_n) begin
        cur_nxt.slv_valid   = 1'b1;
        cur_nxt.slv.write   = 1'b1;
        cur_nxt.slv.addr    = pin_s.addr;            // RULE3
        cur_nxt.slv.wdata   = pin_s.data & lane_mask;
      end
      // Read answer goes out while the read strobe stays low
      if (!pin_s.rd_n && !suspended) begin
        cur_nxt.pins.data    = slv_rdata & lane_mask;
        cur_nxt.pins.data_oe = lane_mask;
      end
    end
  end

  // Enable for a step: half-rate SDRAM waits for the divider
  function automatic logic step_ok(input epas_st_t s);
    logic sd;
    sd = 1'b0;
    if (s.ext) begin
      sd = |(bank_sel_q(s.req.addr, s.cfg.sdram_mask) & s.cfg.sdram_mask);
    end
    step_ok = !(sd && s.cfg.sdram_half) || s.tick; // RULE7
  endfunction

  // Bank decode of the latched address, same layout as the decoder
  function automatic logic [3:0] bank_sel_q(input logic [31:0] a,
                                            input logic [3:0]  m);
    logic [31:0] lo;
    logic [31:0] hi;
    bank_sel_q = '0;
    lo = `EPAS_EXT_BASE;
    for (int i = 0; i < `EPAS_BANKS; i++) begin
      hi = lo + (m[i] ? `EPAS_SDBANK_SZ : `EPAS_BANK_SZ); // RULE10
      bank_sel_q[i] = (a >= lo) && (a < hi);
      lo = hi;
    end
  endfunction

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      cur_r <= '0;
      cur_r.st <= EPAS_IDLE;
      cur_r.cfg <= epas_cfg_t'(`EPAS_CFG_RST);
      cur_r.pins.bank_select_n <= '1;
      cur_r.pins.rd_n <= 1'b1;
      cur_r.pins.wr_n <= 1'b1;
      cur_r.rd_n_d <= 1'b1;
      cur_r.wr_n_d <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Every output is a field of the state register
  assign pins_o     = cur_r.pins;
  assign reg_rdata  = cur_r.reg_rdata;
  assign req_ready  = cur_r.req_ready;
  assign resp_valid = cur_r.resp_valid;
  assign resp_err   = cur_r.resp_err;
  assign resp_rdata = cur_r.resp_rdata;
  assign slv_valid  = cur_r.slv_valid;
  assign slv        = cur_r.slv;
endmodule

// [bench/epas_port_checker.sv]
`timescale 1ns/100ps
// Watches the pins of the port; all checks live in one clock domain
module epas_port_checker
  import epas_pkg::*;
(
  input wire logic         clk,
  input wire logic         srst,
  input wire logic         req_valid,
  input wire logic         req_ready,
  input wire logic         resp_valid,
  input wire logic         resp_err,
  input wire epas_pins_i_t pins_i,
  input wire epas_pins_o_t pins_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ****************************************
  // Helper terms
  // ****************************************
  logic sel_low;
  assign sel_low = pins_o.bank_oe && (pins_o.bank_select_n != 4'hf);
  // Ack seen low two cycles back is what the port acts on now
  sequence s_stalled;
    !pins_i.ack ##2 sel_low;
  endsequence
  sequence s_acked;
    pins_i.ack [*4] ##0 sel_low;
  endsequence
  sequence s_slave;
    !pins_i.bus_master [*4];
  endsequence
  sequence s_susp;
    !pins_i.suspend_bus_tristate_n [*4];
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  a_idle_sel_high: assert property (req_ready && $past(req_ready) &&
    pins_o.bank_oe |-> pins_o.bank_select_n == 4'hf)
    else $error("bank select low while idle");
  a_sel_one_hot: assert property (sel_low |->
    $onehot(~pins_o.bank_select_n)) else $error("select not one hot");
  a_sel_with_addr: assert property (sel_low |-> pins_o.addr_oe)
    else $error("select without address drive");
  a_addr_held: assert property (sel_low && $past(sel_low) |->
    $stable(pins_o.addr)) else $error("address moved under select");
  a_ack_stretch: assert property (s_stalled |=> sel_low)
    else $error("access ended while ack low");
  a_ack_release: assert property (s_acked |-> ##[1:20] !sel_low)
    else $error("select held after ack");
  a_slave_float: assert property (s_slave |-> !pins_o.addr_oe &&
    !pins_o.bank_oe && !pins_o.strobe_oe) else $error("slave drives bus");
  a_susp_float: assert property (s_susp |-> !pins_o.addr_oe &&
    !pins_o.bank_oe && !pins_o.strobe_oe) else $error("suspended bus driven");
  a_slave_refuse: assert property (s_slave ##0 (req_valid && req_ready)
    |=> resp_valid && resp_err) else $error("slave access not refused");
  a_wide_write: assert property (!pins_o.wr_n && pins_o.strobe_oe |->
    &pins_o.data_oe[47:16]) else $error("upper lanes not driven");
endmodule

// [bench/epas_mem_model.sv]
`timescale 1ns/100ps
// External memory: answers every strobe, stretched by a stall count
module epas_mem_model
  import epas_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire epas_pins_o_t pins_o,
  input  wire logic [3:0]   stall,
  output logic              ack,
  output logic [47:0]       data
);
  logic [3:0]  cnt_r;
  logic [47:0] last_r;
  logic        strb;
  assign strb = pins_o.strobe_oe && !(pins_o.rd_n && pins_o.wr_n);
  // Wait states: ack low for the first stall cycles of a strobe
  assign ack = !(strb && (cnt_r < stall));
  // Released lines toggle so a late sample never looks valid
  assign data = (strb && !pins_o.rd_n) ? {pins_o.addr, ~pins_o.addr}
                                       : ~last_r;
  always_ff @(posedge clk) begin
    if (srst || !strb)
      cnt_r <= 4'h0;
    else if (cnt_r != 4'hf)
      cnt_r <= cnt_r + 4'h1;
    last_r <= data;
  end
endmodule

// [bench/test_ext_port_address_select.sv]
`timescale 1ns/100ps
`include "epas_map.svh"
module test_ext_port_address_select;
  import epas_pkg::*;
  typedef struct packed {
    logic        err;
    logic [3:0]  sel;
    logic        rd;
    logic [47:0] rdata;
  } epas_exp_t;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic [3:0]   reg_addr = 4'h0;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic         req_valid = 1'b0;
  epas_req_t    req = '0;
  logic [31:0]  reg_rdata;
  logic         req_ready, resp_valid, resp_err, slv_valid, m_ack;
  logic [47:0]  resp_rdata, m_data;
  epas_slv_t    slv;
  epas_pins_i_t pi, pins_i;
  epas_pins_o_t pins_o;
  logic [3:0]   stall = 4'h0;
  logic [3:0]   sel_seen = 4'hf;
  logic [31:0]  base;
  epas_cfg_t    cfg_v;
  epas_exp_t    expq[$];
  epas_exp_t    w;
  int           bad_count = 0;
  int           checks = 0;
  int           cyc = 0;
  int           n;
  always #2.5 clk = ~clk;
  // Wire level: whoever enables a data bit owns it
  always_comb begin
    pins_i = pi;
    pins_i.ack = m_ack;
    pins_i.data = (pins_o.data & pins_o.data_oe) | (m_data & ~pins_o.data_oe);
  end
  epas_port dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_err(resp_err),
    .resp_rdata(resp_rdata), .slv_valid(slv_valid), .slv(slv),
    .slv_rdata(48'h0000_5a5a_0000), .pins_i(pins_i), .pins_o(pins_o));
  epas_mem_model mem (.clk(clk), .srst(srst), .pins_o(pins_o),
    .stall(stall), .ack(m_ack), .data(m_data));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(48'(reg_rdata & m), 48'(x));
  endtask
  task automatic set_cfg(input epas_cfg_t c);
    cfg_v = c;
    wr_reg(4'h0, 32'(c));
  endtask
  // One core access; the expected answer is queued first
  task automatic acc(input logic ins, wr, input logic [31:0] a,
                     input logic err, input logic [3:0] sel);
    logic [47:0] m;
    m = {32'hffff_ffff, cfg_v.link1_used ? 8'h00 : 8'hff,
         cfg_v.link0_used ? 8'h00 : 8'hff};
    expq.push_back('{err, sel, !wr && !err, {a[23:0], ~a[23:0]} & m});
    @(posedge clk);
    stall <= 4'($urandom_range(0, 4));
    req_valid <= 1'b1;
    req <= '{ins, wr, a, {16'h0, $urandom}};
    n = 0;
    do @(posedge clk); while (req_ready !== 1'b1 && ++n < 50);
    req_valid <= 1'b0;
    n = 0;
    while (expq.size() != 0 && n++ < 60) @(posedge clk);
  endtask
  // Response watcher: oldest note against each answer
  always @(posedge clk) begin
    if (resp_valid === 1'b1) begin
      w = expq.size() ? expq.pop_front() : '1;
      chk(48'(resp_err), 48'(w.err));
      chk(48'(sel_seen), 48'(w.sel));
      if (w.rd)
        chk(resp_rdata, w.rdata);
      sel_seen <= 4'hf;
    end else if (pins_o.bank_oe && pins_o.bank_select_n != 4'hf)
      sel_seen <= pins_o.bank_select_n;
  end
  // Hang guard, far above the planned run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      stop_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    pi = {24'h0, 48'h0, 4'hf, 5'h1f};
    cfg_v = `EPAS_CFG_RST;
    void'($urandom(47314));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(4'h0, 32'h3fff, 32'h000c);
    rd_chk(4'h2, 32'hffff_ffff, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < `EPAS_BANKS; i++) begin
      base = `EPAS_EXT_BASE + i * `EPAS_BANK_SZ + ($urandom & 32'h00ff_ffff);
      acc(1'b0, 1'b0, base, 1'b0, ~(4'h1 << i));
      acc(1'b0, 1'b1, base, 1'b0, ~(4'h1 << i));
    end
    $display("test bank walk done");
    set_cfg(14'h0000);
    acc(1'b1, 1'b0, base, 1'b1, 4'hf);
    rd_chk(4'h1, 32'h2, 32'h2);
    wr_reg(4'h1, 32'h2);
    rd_chk(4'h1, 32'h2, 32'h0);
    set_cfg(`EPAS_PACK_FULL);
    acc(1'b1, 1'b0, base, 1'b0, 4'h7);
    rd_chk(4'h1, 32'h4, 32'h4);
    $display("test wide fetch done");
    // Async then sync at half rate, bank 0 typed as the large kind
    for (int m = 0; m < 2; m++) begin
      set_cfg({4'h3, 4'h1, m[0], m[0], 4'h1});
      acc(1'b0, 1'b0, `EPAS_EXT_BASE + `EPAS_BANK_SZ, 1'b0, 4'he);
      acc(1'b0, 1'b1, `EPAS_EXT_BASE + `EPAS_SDBANK_SZ, 1'b0, 4'hd);
    end
    $display("test modes done");
    acc(1'b0, 1'b1, `EPAS_MP_BASE + 32'h0001_0010, 1'b0, 4'hf);
    acc(1'b0, 1'b1, `EPAS_MP_BASE + 32'h0001_0000 + `EPAS_IOP_SPAN,
        1'b1, 4'hf);
    $display("test peer window done");
    pi.suspend_bus_tristate_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk(48'(pins_o.addr_oe), 48'h0);
    rd_chk(4'h1, 32'h100, 32'h100);
    pi.suspend_bus_tristate_n <= 1'b1;
    $display("test suspend done");
    pi.bus_master <= 1'b0;
    pi.bank_select_n <= 4'h9;
    repeat (6) @(posedge clk);
    acc(1'b0, 1'b0, base, 1'b1, 4'hf);
    rd_chk(4'h1, 32'h1f8, 32'h048);
    pi.addr <= 24'h000123;
    pi.wr_n <= 1'b0;
    n = 0;
    do @(posedge clk); while (slv_valid !== 1'b1 && ++n < 20);
    chk({slv.write, slv.addr}, {23'h0, 1'b1, 24'h000123});
    pi.wr_n <= 1'b1;
    pi.rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk(pins_o.data & pins_o.data_oe, 48'h0000_5a5a_0000);
    chk(48'(slv.write), 48'h0);
    pi.rd_n <= 1'b1;
    $display("test slave done");
    chk(48'(expq.size()), 48'h0);
    stop_test();
  end
endmodule
bind epas_port epas_port_checker u_chk (.clk(clk), .srst(srst),
  .req_valid(req_valid), .req_ready(req_ready), .resp_valid(resp_valid),
  .resp_err(resp_err), .pins_i(pins_i), .pins_o(pins_o));
